// >>> design/pmc_pkg.sv
/*
 * Constants and types shared by the power mode control block.
 * Assumes a 125 MHz system clock and an Avalon-MM register bus with 32-bit data.
 */
// Functional notes
// [R01] Idle bit write gates processor clock.
// [R02] Idle keeps state, peripheral clocks running.
// [R03] Enabled interrupt or reset ends idle.
// [R04] Interrupt wake clears idle, resumes next.
// [R05] Reset wake restarts at address zero.
// [R06] Watchdog timeout resets out of idle.
// [R07] Stop bit halts processor, oscillators, clock.
// [R08] Stop silences interrupts, timers except detector.
// [R09] Only reset leaves stop, restart zero.
// [R10] Missing clock detector resets after 100us.
// [R11] Stop bit always reads zero.
// [R12] Idle bit always reads zero.
// [R13] Software follows idle with multibyte instruction.
// [R14] Both bits set chooses stop.
package pmc_pkg;

    // Register map: printed offset 0x87 is not a multiple of four, so it is an index.
    localparam logic [7:0]  PMC_REQ_INDEX    = 8'h87;
    localparam logic [9:0]  PMC_REQ_BYTE     = 10'h021C;
    localparam logic [7:0]  PMC_REQ_RESET    = 8'h00;
    localparam int          PMC_IDLE_BIT     = 0;
    localparam int          PMC_STOP_BIT     = 1;
    localparam logic [31:0] PMC_READ_ZERO    = 32'h0000_0000;
    localparam logic [19:0] PMC_RESET_VECTOR = 20'h0_0000;

    // Missing clock detector timeout.
    localparam int PMC_CLK_MHZ       = 125;
    localparam int PMC_DET_US        = 100;
    localparam int PMC_DET_CYCLES    = PMC_DET_US * PMC_CLK_MHZ;

    // Power states.
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_STOP
    } pmc_state_type;

endpackage : pmc_pkg

// >>> design/pmc_top.sv
/*
 * Power mode control: idle and stop states of the processor core.
 * Assumes an Avalon-MM master on the same clock, and that the watchdog,
 * interrupt controller and reset pin are outside; their inputs are synchronised here.
 */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps

module pmc_top
    import pmc_pkg::*;
#(
    parameter int DET_CYCLES = PMC_DET_CYCLES
)
(
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic [9:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    input  wire logic        INSTR_DONE_IN,
    input  wire logic        IRQ_ENABLED_IN,
    input  wire logic        WATCHDOG_TIMER_EXPIRED_IN,
    input  wire logic        DETECTOR_ENABLE_IN,
    input  wire logic        EXT_RESET_IN,
    output logic             CPU_CLK_EN_OUT,
    output logic             PERIPH_CLK_EN_OUT,
    output logic             OSC_EN_OUT,
    output logic             IRQ_GATE_OUT,
    output logic             IDLE_WAKE_OUT,
    output logic             SYS_RESET_OUT,
    output logic      [19:0] RESET_VECTOR_OUT,
    output logic      [1:0]  POWER_STATE_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        pmc_state_type state;
        logic          pend_idle;
        logic          pend_stop;
        logic          ack;
        logic [31:0]   rdata;
        logic [2:0]    irq_s;
        logic [2:0]    dog_s;
        logic [2:0]    ext_s;
        logic [1:0]    det_en_s;
        logic [31:0]   det_cnt;
        logic          reset_out;
        logic          wake;
    } pmc_regs_type;

    pmc_regs_type r;
    pmc_regs_type next_r;

    logic access;
    logic hit;
    logic wr_hit;
    logic irq_live;
    logic dog_live;
    logic ext_live;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode and synchronised inputs (bit 0 is first stage, only bit 1 is read).

    assign access   = (AVS_READ_IN || AVS_WRITE_IN) && !r.ack;
    assign hit      = AVS_ADDRESS_IN == PMC_REQ_BYTE;
    // A write takes effect only at the edge where waitrequest is low (second cycle).
    assign wr_hit   = AVS_WRITE_IN && r.ack && hit && AVS_BYTEENABLE_IN[0];
    assign irq_live = r.irq_s[1];
    assign dog_live = r.dog_s[1];
    assign ext_live = r.ext_s[1];

    // Next state.
    always_comb
    begin
        next_r          = r;
        next_r.irq_s    = {r.irq_s[1], r.irq_s[0], IRQ_ENABLED_IN};
        next_r.dog_s    = {r.dog_s[1], r.dog_s[0], WATCHDOG_TIMER_EXPIRED_IN};
        next_r.ext_s    = {r.ext_s[1], r.ext_s[0], EXT_RESET_IN};
        next_r.det_en_s = {r.det_en_s[0], DETECTOR_ENABLE_IN};
        next_r.ack      = access;
        next_r.reset_out = 1'b0;
        next_r.wake     = 1'b0;
        // Request bits are write-only triggers; reads return zero.
        next_r.rdata    = PMC_READ_ZERO; // [R11] [R12]
        if (wr_hit)
        begin
            next_r.pend_idle = AVS_WRITEDATA_IN[PMC_IDLE_BIT];
            next_r.pend_stop = AVS_WRITEDATA_IN[PMC_STOP_BIT];
        end
        case (r.state)
            PMC_RUN:
            begin
                next_r.det_cnt = '0;
                // Entry waits for the writing instruction to complete.
                if (INSTR_DONE_IN && r.pend_stop)
                begin
                    next_r.state     = PMC_STOP; // [R07] [R14]
                    next_r.pend_stop = 1'b0;
                    next_r.pend_idle = 1'b0;
                end
                else if (INSTR_DONE_IN && r.pend_idle)
                begin
                    next_r.state = PMC_IDLE; // [R01]
                end
            end
            PMC_IDLE:
            begin
                if (dog_live || ext_live)
                begin
                    next_r.state     = PMC_RUN; // [R03] [R05] [R06]
                    next_r.pend_idle = 1'b0;
                    next_r.reset_out = 1'b1;
                end
                else if (irq_live)
                begin
                    // Clear the request; the core services the interrupt then resumes.
                    next_r.state     = PMC_RUN; // [R03] [R04]
                    next_r.pend_idle = 1'b0;
                    next_r.wake      = 1'b1;
                end
            end
            PMC_STOP:
            begin
                // Only the detector counts; it counts CLK_IN cycles while its synchronised enable is set.
                if (r.det_en_s[1])
                begin
                    next_r.det_cnt = r.det_cnt + 32'h0000_0001;
                end
                if (ext_live || (r.det_en_s[1] && r.det_cnt >= 32'(DET_CYCLES - 1)))
                begin
                    next_r.state     = PMC_RUN; // [R09] [R10]
                    next_r.reset_out = 1'b1;
                    next_r.det_cnt   = '0;
                end
            end
            default:
            begin
                next_r.state = PMC_RUN;
            end
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge CLK_IN)
    begin
        if (!NRST_IN)
        begin
            r       <= '0;
            r.state <= PMC_RUN;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !r.ack;
    assign AVS_READDATA_OUT    = r.rdata;
    // Peripherals, timers and interrupt logic stay clocked in idle.
    assign CPU_CLK_EN_OUT      = r.state == PMC_RUN; // [R01] [R02]
    assign PERIPH_CLK_EN_OUT   = r.state != PMC_STOP; // [R02] [R07]
    assign OSC_EN_OUT          = r.state != PMC_STOP; // [R07]
    assign IRQ_GATE_OUT        = r.state != PMC_STOP; // [R08]
    assign IDLE_WAKE_OUT       = r.wake;
    assign SYS_RESET_OUT       = r.reset_out;
    assign RESET_VECTOR_OUT    = PMC_RESET_VECTOR; // [R05] [R09]
    assign POWER_STATE_OUT     = r.state;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    stop_wins_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R14]
        (r.state == PMC_RUN && INSTR_DONE_IN && r.pend_stop) |=> r.state == PMC_STOP)
        else $error("stop request did not enter stop");
    idle_entry_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R01]
        (r.state == PMC_RUN && INSTR_DONE_IN && r.pend_idle && !r.pend_stop) |=> !CPU_CLK_EN_OUT)
        else $error("idle request did not gate cpu clock");
    idle_clocks_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R02]
        r.state == PMC_IDLE |-> PERIPH_CLK_EN_OUT && IRQ_GATE_OUT)
        else $error("peripheral clocks stopped in idle");
    irq_wake_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R04]
        (r.state == PMC_IDLE && irq_live && !dog_live && !ext_live) |=> IDLE_WAKE_OUT && !r.pend_idle)
        else $error("interrupt did not wake idle");
    wdt_reset_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R06]
        (r.state == PMC_IDLE && dog_live) |=> SYS_RESET_OUT && r.state == PMC_RUN)
        else $error("watchdog did not reset idle");
    stop_quiet_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R08]
        r.state == PMC_STOP |-> !IRQ_GATE_OUT && !OSC_EN_OUT && !CPU_CLK_EN_OUT)
        else $error("activity in stop");
    stop_exit_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R09]
        ($past(r.state) == PMC_STOP && r.state != PMC_STOP) |-> SYS_RESET_OUT)
        else $error("stop left without reset");
    read_zero_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN) // [R11] [R12]
        (AVS_READ_IN && !AVS_WAITREQUEST_OUT) |-> AVS_READDATA_OUT == PMC_READ_ZERO)
        else $error("request bits read nonzero");

endmodule : pmc_top

// >>> verif/pmc_top_bench.sv
/* Bench for pmc_top: a table of register writes, then wake, watchdog, detector and reset cases.
   Assumes the design's own assertions run beside it and a short detector count. */
`timescale 1ns/10ps
module pmc_top_bench;
    import pmc_pkg::*;
    typedef struct packed {logic [9:0] a; logic [3:0] b; logic [1:0] d; logic [1:0] s;} pmc_row_type;
    logic        clk, nrst, rd, wr, done, irq, dog, det, ext, wrq, cpu, per, osc, gate, wake, srst;
    logic [9:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata, rdata, got;
    logic [19:0] vec;
    logic [1:0]  st;
    int          failures, n_compared, k;
    pmc_row_type rows [6] = '{'{10'h21C, 4'hE, 2'h1, 2'h0}, '{10'h218, 4'hF, 2'h1, 2'h0},
        '{10'h21C, 4'hF, 2'h0, 2'h0}, '{10'h21C, 4'hF, 2'h1, 2'h1}, '{10'h21C, 4'hF, 2'h2, 2'h2},
        '{10'h21C, 4'hF, 2'h3, 2'h2}};

    // The block runs with a 20-cycle detector so the stop timeout stays short.
    pmc_top #(.DET_CYCLES(20)) u_pmc_top (
        .CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(wrq), .INSTR_DONE_IN(done), .IRQ_ENABLED_IN(irq),
        .WATCHDOG_TIMER_EXPIRED_IN(dog), .DETECTOR_ENABLE_IN(det), .EXT_RESET_IN(ext),
        .CPU_CLK_EN_OUT(cpu), .PERIPH_CLK_EN_OUT(per), .OSC_EN_OUT(osc), .IRQ_GATE_OUT(gate),
        .IDLE_WAKE_OUT(wake), .SYS_RESET_OUT(srst), .RESET_VECTOR_OUT(vec), .POWER_STATE_OUT(st));

    // The 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // A wait that ran out counts as a mismatch and ends the run.
    task hang;
        failures++;
        give_verdict();
    endtask : hang

    // Compares one value and reports a mismatch at once.
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Checks state and clock enables: core runs only in run, the rest stop only in stop.
    task chk_st(input logic [1:0] s);
        @(negedge clk);
        chk({26'h0, st, cpu, per, osc, gate}, {26'h0, s, s == 2'h0, {3{s != 2'h2}}});
        @(posedge clk);
    endtask : chk_st

    // One Avalon transfer, held until waitrequest is seen low at a rising edge.
    task bus(input logic w, input logic [9:0] a, input logic [3:0] b, input logic [31:0] d);
        int i;
        rd    <= !w;
        wr    <= w;
        addr  <= a;
        be    <= b;
        wdata <= d;
        for (i = 0; i < 8; i++)
        begin
            @(posedge clk);
            if (wrq === 1'b0)
                break;
        end
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 8)
            hang();
        @(posedge clk);
    endtask : bus

    // Ends the instruction that wrote the request.
    task step;
        done <= 1'b1; // The next instruction is taken as a multibyte one.
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : step

    // Raises a wake cause (0 external reset, 1 watchdog, 2 interrupt; for 3 the caller enables the detector) and awaits run.
    task leave(input int src);
        int i;
        if (src < 3)
            {ext, dog, irq} <= 3'b100 >> src;
        for (i = 0; i < 40; i++)
        begin
            @(negedge clk);
            if ((src == 2 ? wake : srst) === 1'b1)
                break;
        end
        @(posedge clk);
        if (src < 3)
            {ext, dog, irq} <= 3'b000;
        if (i == 40)
            hang();
        chk({12'h0, vec}, {12'h0, PMC_RESET_VECTOR});
        chk_st(2'h0);
    endtask : leave

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reset, the table of writes, then the hand-written cases.
    initial
    begin
        {nrst, rd, wr, done, irq, dog, det, ext} = 8'h00;
        addr = 10'h000;
        be = 4'hF;
        wdata = 32'h0000_0000;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 6; k++)
        begin
            bus(1'b1, rows[k].a, rows[k].b, {30'h0, rows[k].d});
            bus(1'b0, rows[k].a, 4'hF, 32'h0000_0000);
            chk(got, PMC_READ_ZERO);
            chk_st(2'h0);
            step();
            chk_st(rows[k].s);
            if (rows[k].s != 2'h0)
                leave(0);
        end
        // Interrupt wake clears the request, so a later instruction end stays in run.
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0001);
        step();
        leave(2);
        step();
        chk_st(2'h0);
        // Watchdog ends idle; peripheral clocks run meanwhile.
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0001);
        step();
        chk_st(2'h1);
        leave(1);
        // Stop ignores interrupt and watchdog; here the detector ends it.
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0002);
        step();
        irq <= 1'b1;
        dog <= 1'b1;
        repeat (8) @(posedge clk);
        chk_st(2'h2);
        irq <= 1'b0;
        dog <= 1'b0;
        det <= 1'b1;
        leave(3);
        det <= 1'b0;
        // A second write replaces the first; a chip reset in mid-stop returns to run.
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0002);
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0001);
        step();
        chk_st(2'h1);
        leave(0);
        bus(1'b1, PMC_REQ_BYTE, 4'hF, 32'h0000_0002);
        step();
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk_st(2'h0);
        give_verdict();
    end
endmodule : pmc_top_bench
